// [verilog/aspc_pkg.sv]
// Package: register map, field positions and shared types of the audio serial port
package aspc_pkg;

	// Register byte offsets
	localparam logic [7:0] ASPC_OFF_CONTROL = 8'h00;
	localparam logic [7:0] ASPC_OFF_CLKDIV = 8'h04;
	localparam logic [7:0] ASPC_OFF_IRQ_EN = 8'h08;
	localparam logic [7:0] ASPC_OFF_STATUS = 8'h0C;
	localparam logic [7:0] ASPC_OFF_TX_FIFO = 8'h10;
	localparam logic [7:0] ASPC_OFF_RX_FIFO = 8'h14;

	// Control field positions
	localparam int ASPC_CON_PCM = 24;
	localparam int ASPC_CON_RX_LEFT = 23;
	localparam int ASPC_CON_RX_DMA = 21;
	localparam int ASPC_CON_TX_DMA = 20;
	localparam int ASPC_CON_RX_CLR = 19;
	localparam int ASPC_CON_TX_CLR = 18;
	localparam int ASPC_CON_LZC_EN = 17;
	localparam int ASPC_CON_RZC_EN = 16;
	localparam int ASPC_CON_MCLK_EN = 15;
	localparam int ASPC_CON_RX_TH = 12;
	localparam int ASPC_CON_TX_TH = 9;
	localparam int ASPC_CON_SLAVE = 8;
	localparam int ASPC_CON_FORMAT = 7;
	localparam int ASPC_CON_MONO = 6;
	localparam int ASPC_CON_WIDTH = 4;
	localparam int ASPC_CON_MUTE = 3;
	localparam int ASPC_CON_RX_EN = 2;
	localparam int ASPC_CON_TX_EN = 1;
	localparam int ASPC_CON_ENABLE = 0;

	// Writable masks and reset values
	localparam logic [31:0] ASPC_CON_MASK = 32'h01BF_FFFF;
	localparam logic [31:0] ASPC_CLKDIV_MASK = 32'h0000_FF07;
	localparam logic [31:0] ASPC_IE_MASK = 32'h0000_1F07;
	localparam logic [31:0] ASPC_RESET_ZERO = 32'h0000_0000;
	localparam logic [31:0] ASPC_STATUS_RESET = 32'h0014_1000;

	// Status field positions
	localparam int ASPC_ST_LEFT_ZERO_CROSS_FLAG = 23;
	localparam int ASPC_ST_RIGHT_ZERO_CROSS_FLAG = 22;
	localparam int ASPC_ST_TX_OVERFLOW_FLAG = 17;
	localparam int ASPC_ST_TX_UNDERFLOW_FLAG = 16;
	localparam int ASPC_ST_RX_OVERFLOW_FLAG = 9;
	localparam int ASPC_ST_RX_UNDERFLOW_FLAG = 8;

	// FIFO depth
	localparam int ASPC_FIFO_DEPTH = 8;

	// Sample sizes
	typedef enum logic [1:0]
	{
		ASPC_W8 = 2'h0,
		ASPC_W16 = 2'h1,
		ASPC_W24 = 2'h2,
		ASPC_W32 = 2'h3
	} aspc_width_t;

	// Serial pins driven to the codec
	typedef struct packed
	{
		logic bclk_o;
		logic bclk_oe;
		logic lrclk_o;
		logic lrclk_oe;
		logic data_o;
		logic mclk_o;
	} aspc_pins_out_t;

	// DMA requests
	typedef struct packed
	{
		logic tx_req;
		logic rx_req;
	} aspc_dma_t;

endpackage : aspc_pkg

// [verilog/aspc_fifo.sv]
// Eight-word data FIFO with clear, level and overwrite-on-full option
`timescale 1ns/10ps
module aspc_fifo
	import aspc_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = ASPC_FIFO_DEPTH
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Control
	input wire logic clear,
	input wire logic overwrite,
	// Write side
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	// Read side
	input wire logic pop,
	output logic [WIDTH-1:0] pop_data,
	// State
	output logic [$clog2(DEPTH):0] level
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic full;
	logic empty;
	logic do_push;
	logic do_pop;
	logic drop_oldest;

	// Elaboration check: pointers wrap only for a power-of-two depth
	if (DEPTH != (1 << AW) || DEPTH < 2)
	begin : g_bad_depth
		$error("aspc_fifo: DEPTH must be a power of two");
	end

	assign full = (level == DEPTH[AW:0]);
	assign empty = (level == '0);
	assign do_pop = pop && !empty;
	assign do_push = push && (!full || overwrite);
	// When full, a push that overwrites discards the oldest word
	assign drop_oldest = do_push && full && !do_pop;
	assign pop_data = mem[rd_ptr];

	// Storage; a clear does not erase the contents
	always_ff @(posedge clock)
	begin
		if (do_push)
			mem[wr_ptr] <= push_data;
	end

	// Pointers and level
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end
		else if (clear)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop || drop_oldest)
				rd_ptr <= rd_ptr + 1'b1;
			if (do_push && !do_pop && !full)
				level <= level + 1'b1;
			else if (do_pop && !do_push)
				level <= level - 1'b1;
		end
	end

endmodule : aspc_fifo

// [verilog/aspc_top.sv]
// Audio serial port controller: APB registers, FIFOs, clocks and serial engine
//
// Summary of operation
// - format bit: I2S or justified; PCM bit stored but unused
// - mono receive keeps left or right channel
// - rx DMA request while rx FIFO non-empty
// - tx DMA request while tx FIFO not full
// - rx clear empties FIFO, self-clearing bit
// - tx clear resets pointers, keeps data
// - left zero-cross: sign change or zero
// - right zero-cross with own enable
// - master clock source or source/(2*div)
// - bit clock source/(2*(div+1)) in master
// - rx threshold flag at level>=th+1
// - tx threshold flag at level<=th
// - master drives clocks, slave receives them
// - mono bit selects single channel, receive only
// - width field selects 8/16/24/32 bits
// - mute sends zeros instead of data
// - rx, tx and controller enables
// - tx threshold interrupt when level below threshold
// - tx overflow and underflow interrupts
// - rx threshold, overflow, underflow interrupts
// - reading empty rx FIFO sets underflow
// - left and right zero-cross interrupts
// - status levels and reset value
// - rx overflow overwrites oldest word
// - tx fetch on empty sets underflow
// - tx write when full sets overflow
// - summary status is tx OR rx
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module aspc_top
	import aspc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Codec link pins
	input wire logic bclk_i,
	input wire logic lrclk_i,
	input wire logic data_i,
	output aspc_pins_out_t pins,
	// DMA and interrupt
	output aspc_dma_t dma,
	output logic irq
);

	//**********************************************************************
	// Registers
	//**********************************************************************
	logic [31:0] control;
	logic [31:0] clkdiv;
	logic [31:0] irq_en;
	logic left_zero_cross_flag, right_zero_cross_flag, tx_overflow_flag, tx_underflow_flag, rx_overflow_flag, rx_underflow_flag;
	logic [3:0] tx_level, rx_level;
	logic [31:0] tx_head, rx_head;
	logic tx_pop, rx_push, rx_pop;
	logic [31:0] rx_word;
	logic wr_en, rd_en;
	logic tx_busy, cur_right;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;

	wire logic enable = control[ASPC_CON_ENABLE];
	wire logic tx_on = enable && control[ASPC_CON_TX_EN];
	wire logic rx_on = enable && control[ASPC_CON_RX_EN];
	wire logic slave = control[ASPC_CON_SLAVE];
	wire logic mono = control[ASPC_CON_MONO];
	wire logic justified = control[ASPC_CON_FORMAT];
	wire logic pcm = control[ASPC_CON_PCM];
	wire aspc_width_t width = aspc_width_t'(control[ASPC_CON_WIDTH +: 2]);
	wire logic [2:0] rx_th = control[ASPC_CON_RX_TH +: 3];
	wire logic [2:0] tx_th = control[ASPC_CON_TX_TH +: 3];

	wire logic tx_full = (tx_level == 4'h8);
	wire logic tx_empty = (tx_level == 4'h0);
	wire logic rx_full = (rx_level == 4'h8);
	wire logic rx_empty = (rx_level == 4'h0);
	wire logic rx_threshold_flag = ({1'b0, rx_level} >= ({2'h0, rx_th} + 5'h01));
	wire logic tx_threshold_flag = (tx_level <= {1'b0, tx_th});
	wire logic tx_write = wr_en && (paddr == ASPC_OFF_TX_FIFO);
	wire logic rx_read = rd_en && (paddr == ASPC_OFF_RX_FIFO);
	wire logic tx_clear = wr_en && (paddr == ASPC_OFF_CONTROL) && pwdata[ASPC_CON_TX_CLR];
	wire logic rx_clear = wr_en && (paddr == ASPC_OFF_CONTROL) && pwdata[ASPC_CON_RX_CLR];

	// Interrupt sources
	wire logic tx_int = (irq_en[10] && ({1'b0, tx_level} < {2'h0, tx_th}))
		|| (irq_en[9] && tx_overflow_flag) || (irq_en[8] && tx_underflow_flag)
		|| (irq_en[12] && left_zero_cross_flag) || (irq_en[11] && right_zero_cross_flag);
	wire logic rx_int = (irq_en[2] && rx_threshold_flag) || (irq_en[1] && rx_overflow_flag)
		|| (irq_en[0] && rx_underflow_flag);
	wire logic any_int = tx_int || rx_int;

	// Control, divider and enable registers; clear bits never stored
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			control <= ASPC_RESET_ZERO;
			clkdiv <= ASPC_RESET_ZERO;
			irq_en <= ASPC_RESET_ZERO;
		end
		else if (wr_en)
		begin
			if (paddr == ASPC_OFF_CONTROL)
				control <= pwdata & ASPC_CON_MASK & ~32'h000C_0000;
			if (paddr == ASPC_OFF_CLKDIV)
				clkdiv <= pwdata & ASPC_CLKDIV_MASK;
			if (paddr == ASPC_OFF_IRQ_EN)
				irq_en <= pwdata & ASPC_IE_MASK;
		end
	end

	//**********************************************************************
	// FIFOs
	//**********************************************************************
	aspc_fifo #(.WIDTH(32), .DEPTH(ASPC_FIFO_DEPTH)) u_tx_fifo
	(
		.clock(clock),
		.rst_n(rst_n),
		.clear(tx_clear),
		.overwrite(1'b0),
		.push(tx_write),
		.push_data(pwdata),
		.pop(tx_pop),
		.pop_data(tx_head),
		.level(tx_level)
	);

	aspc_fifo #(.WIDTH(32), .DEPTH(ASPC_FIFO_DEPTH)) u_rx_fifo
	(
		.clock(clock),
		.rst_n(rst_n),
		.clear(rx_clear),
		.overwrite(1'b1),
		.push(rx_push),
		.push_data(rx_word),
		.pop(rx_pop),
		.pop_data(rx_head),
		.level(rx_level)
	);
	assign rx_pop = rx_read;

	//**********************************************************************
	// Clock generation and link synchronisers
	//**********************************************************************
	logic [7:0] bdiv_cnt;
	logic [2:0] mdiv_cnt;
	logic bclk_gen, lr_gen, mclk_tog;
	logic [5:0] lr_cnt;
	logic [1:0] bclk_s, lrclk_s, data_s;
	logic bclk_q, lrclk_q;
	wire logic [5:0] half_bits = (width == ASPC_W8) ? 6'd7 : (width == ASPC_W16) ? 6'd15
		: 6'd31;

	// Bit clock and frame clock divider in master mode
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bdiv_cnt <= '0;
			bclk_gen <= 1'b0;
			lr_gen <= 1'b0;
			lr_cnt <= '0;
		end
		else if (!enable || slave)
		begin
			bdiv_cnt <= '0;
			bclk_gen <= 1'b0;
			lr_gen <= 1'b0;
			lr_cnt <= '0;
		end
		else if (bdiv_cnt == clkdiv[15:8])
		begin
			bdiv_cnt <= '0;
			bclk_gen <= !bclk_gen;
			if (bclk_gen)
			begin
				lr_cnt <= (lr_cnt == half_bits) ? 6'd0 : lr_cnt + 6'd1;
				if (lr_cnt == half_bits)
					lr_gen <= !lr_gen;
			end
		end
		else
			bdiv_cnt <= bdiv_cnt + 8'h01;
	end

	// Master clock divider
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mdiv_cnt <= '0;
			mclk_tog <= 1'b0;
		end
		else if (!control[ASPC_CON_MCLK_EN])
		begin
			mdiv_cnt <= '0;
			mclk_tog <= 1'b0;
		end
		else if (mdiv_cnt + 3'h1 >= clkdiv[2:0])
		begin
			mdiv_cnt <= '0;
			mclk_tog <= !mclk_tog;
		end
		else
			mdiv_cnt <= mdiv_cnt + 3'h1;
	end

	// Two-stage synchronisers for slave clocks and receive data
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bclk_s <= '0;
			lrclk_s <= '0;
			data_s <= '0;
		end
		else
		begin
			bclk_s <= {bclk_s[0], bclk_i};
			lrclk_s <= {lrclk_s[0], lrclk_i};
			data_s <= {data_s[0], data_i};
		end
	end

	wire logic bclk_now = slave ? bclk_s[1] : bclk_gen;
	wire logic lrclk_now = slave ? lrclk_s[1] : lr_gen;

	// Edge history of the active bit and frame clocks
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bclk_q <= 1'b0;
			lrclk_q <= 1'b0;
		end
		else
		begin
			bclk_q <= bclk_now;
			if (bclk_now && !bclk_q)
				lrclk_q <= lrclk_now;
		end
	end

	wire logic bit_rise = bclk_now && !bclk_q;
	wire logic bit_fall = !bclk_now && bclk_q;
	// Frame edge seen at a rising bit clock; PCM uses the same pulse framing
	wire logic frame_edge = bit_rise && (lrclk_now != lrclk_q);
	wire logic lead_now = justified;

	//**********************************************************************
	// Serial engine
	//**********************************************************************
	logic [31:0] tx_shift, rx_shift, tx_hold, rx_pack;
	logic [5:0] bit_cnt;
	logic [1:0] pack_idx, rx_idx;
	logic delay_pend, prev_sign_l, prev_sign_r;
	logic data_out;
	wire logic [5:0] nbits = half_bits + 6'd1;
	wire logic [1:0] per_word = (width == ASPC_W8) ? 2'd3 : (width == ASPC_W16) ? 2'd1
		: 2'd0;
	// Channel after the frame edge: low frame clock is left
	wire logic next_right = lrclk_now;
	wire logic [31:0] next_sample = (width == ASPC_W8) ? {tx_hold[8*pack_idx +: 8], 24'h0}
		: (width == ASPC_W16) ? {tx_hold[16*pack_idx[0] +: 16], 16'h0}
		: (width == ASPC_W24) ? {tx_hold[23:0], 8'h0} : tx_hold;
	wire logic need_word = (pack_idx == 2'd0);

	assign tx_pop = tx_on && frame_edge && need_word && !tx_empty;

	// Transmit shifter, MSB first, zeros while muted
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_shift <= '0;
			tx_hold <= '0;
			pack_idx <= '0;
			tx_busy <= 1'b0;
			cur_right <= 1'b0;
			delay_pend <= 1'b0;
			data_out <= 1'b0;
			bit_cnt <= '0;
		end
		else if (!tx_on || tx_clear)
		begin
			tx_busy <= 1'b0;
			pack_idx <= '0;
			data_out <= 1'b0;
			delay_pend <= 1'b0;
		end
		else
		begin
			if (frame_edge)
			begin
				cur_right <= next_right;
				bit_cnt <= '0;
				tx_busy <= !tx_empty || !need_word;
				tx_shift <= control[ASPC_CON_MUTE] ? 32'h0
					: need_word ? (width == ASPC_W24 ? {tx_head[23:0], 8'h0}
					: width == ASPC_W32 ? tx_head
					: width == ASPC_W16 ? {tx_head[15:0], 16'h0}
					: {tx_head[7:0], 24'h0}) : next_sample;
				if (need_word)
					tx_hold <= tx_head;
				pack_idx <= (pack_idx == per_word) ? 2'd0 : pack_idx + 2'd1;
				delay_pend <= !lead_now;
			end
			// Shift on falling bit clock; I2S waits one bit first
			if (bit_fall)
			begin
				if (delay_pend)
					delay_pend <= 1'b0;
				else if (bit_cnt < nbits)
				begin
					data_out <= tx_shift[31];
					tx_shift <= {tx_shift[30:0], 1'b0};
					bit_cnt <= bit_cnt + 6'd1;
				end
				else
					data_out <= 1'b0;
			end
		end
	end

	logic rx_right;
	logic [5:0] rx_cnt;
	wire logic rx_keep = !mono || (rx_right != control[ASPC_CON_RX_LEFT]);
	wire logic [31:0] rx_next = {rx_shift[30:0], data_s[1]};
	// I2S slot ends on the next frame edge, justified on its own last bit
	wire logic rx_done = bit_rise && (rx_cnt == nbits - 6'd1) && (!frame_edge || !lead_now);
	wire logic [31:0] rx_sample = (width == ASPC_W24) ? {8'h0, rx_next[23:0]}
		: rx_next;

	// Receive shifter and packer; a word is pushed when the last slot packed into it completes
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_shift <= '0;
			rx_pack <= '0;
			rx_idx <= '0;
			rx_cnt <= 6'h3F;
			rx_right <= 1'b0;
			rx_push <= 1'b0;
			rx_word <= '0;
		end
		else
		begin
			rx_push <= 1'b0;
			if (!rx_on || rx_clear)
			begin
				rx_idx <= '0;
				rx_cnt <= 6'h3F;
			end
			else
			begin
				// Count stays parked until the first frame edge
				if (frame_edge)
				begin
					rx_right <= next_right;
					rx_cnt <= lead_now ? 6'd1 : 6'd0;
					rx_shift <= lead_now ? {31'h0, data_s[1]} : '0;
				end
				else if (bit_rise && rx_cnt < nbits)
				begin
					rx_shift <= rx_next;
					rx_cnt <= rx_cnt + 6'd1;
				end
				if (rx_done && rx_keep)
				begin
					rx_idx <= (rx_idx == per_word) ? 2'd0 : rx_idx + 2'd1;
					if (width == ASPC_W8)
						rx_pack[8*rx_idx +: 8] <= rx_next[7:0];
					else if (width == ASPC_W16)
						rx_pack[16*rx_idx[0] +: 16] <= rx_next[15:0];
					if (rx_idx == per_word)
					begin
						rx_push <= 1'b1;
						rx_word <= (width == ASPC_W8) ? {rx_next[7:0], rx_pack[23:0]}
							: (width == ASPC_W16) ? {rx_next[15:0], rx_pack[15:0]}
							: rx_sample;
					end
				end
			end
		end
	end

	//**********************************************************************
	// Status flags: hardware set wins over write-one-to-clear
	//**********************************************************************
	wire logic st_wr = wr_en && (paddr == ASPC_OFF_STATUS);
	wire logic zc_hit = frame_edge && tx_on
		&& ((next_sample[31] != tx_shift[31]) || next_sample == 32'h0);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			left_zero_cross_flag <= 1'b0;
			right_zero_cross_flag <= 1'b0;
			tx_overflow_flag <= 1'b0;
			tx_underflow_flag <= 1'b0;
			rx_overflow_flag <= 1'b0;
			rx_underflow_flag <= 1'b0;
			prev_sign_l <= 1'b0;
			prev_sign_r <= 1'b0;
		end
		else
		begin
			if (zc_hit && !next_right && control[ASPC_CON_LZC_EN])
				left_zero_cross_flag <= 1'b1;
			else if (st_wr && pwdata[ASPC_ST_LEFT_ZERO_CROSS_FLAG])
				left_zero_cross_flag <= 1'b0;
			if (zc_hit && next_right && control[ASPC_CON_RZC_EN])
				right_zero_cross_flag <= 1'b1;
			else if (st_wr && pwdata[ASPC_ST_RIGHT_ZERO_CROSS_FLAG])
				right_zero_cross_flag <= 1'b0;
			if (tx_write && tx_full)
				tx_overflow_flag <= 1'b1;
			else if (st_wr && pwdata[ASPC_ST_TX_OVERFLOW_FLAG])
				tx_overflow_flag <= 1'b0;
			if (tx_on && frame_edge && need_word && tx_empty)
				tx_underflow_flag <= 1'b1;
			else if (st_wr && pwdata[ASPC_ST_TX_UNDERFLOW_FLAG])
				tx_underflow_flag <= 1'b0;
			if (rx_push && rx_full && !rx_pop)
				rx_overflow_flag <= 1'b1;
			else if (st_wr && pwdata[ASPC_ST_RX_OVERFLOW_FLAG])
				rx_overflow_flag <= 1'b0;
			if (rx_read && rx_empty)
				rx_underflow_flag <= 1'b1;
			else if (st_wr && pwdata[ASPC_ST_RX_UNDERFLOW_FLAG])
				rx_underflow_flag <= 1'b0;
			prev_sign_l <= left_zero_cross_flag;
			prev_sign_r <= right_zero_cross_flag;
		end
	end

	//**********************************************************************
	// APB read data, pins, DMA and interrupt outputs
	//**********************************************************************
	wire logic [31:0] status_word = {tx_level, rx_level, left_zero_cross_flag, right_zero_cross_flag, tx_busy, tx_empty,
		tx_full, tx_threshold_flag, tx_overflow_flag, tx_underflow_flag, 3'h0, rx_empty, rx_full, rx_threshold_flag, rx_overflow_flag, rx_underflow_flag,
		4'h0, cur_right, tx_int, rx_int, any_int};

	// Registered read data, ready on the first access cycle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (paddr > ASPC_OFF_RX_FIFO || paddr[1:0] != 2'h0);
			case (paddr)
				ASPC_OFF_CONTROL: prdata <= control;
				ASPC_OFF_CLKDIV: prdata <= clkdiv;
				ASPC_OFF_IRQ_EN: prdata <= irq_en;
				ASPC_OFF_STATUS: prdata <= status_word;
				ASPC_OFF_RX_FIFO: prdata <= rx_head;
				default: prdata <= '0;
			endcase
		end
	end

	// Link pins, DMA requests and interrupt
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pins <= '0;
			dma <= '0;
			irq <= 1'b0;
		end
		else
		begin
			pins.bclk_o <= bclk_gen;
			pins.lrclk_o <= lr_gen;
			pins.bclk_oe <= enable && !slave;
			pins.lrclk_oe <= enable && !slave;
			pins.data_o <= data_out;
			pins.mclk_o <= (clkdiv[2:0] == 3'h0) ? clock : mclk_tog;
			dma.rx_req <= control[ASPC_CON_RX_DMA] && !rx_empty;
			dma.tx_req <= control[ASPC_CON_TX_DMA] && !tx_full;
			irq <= any_int;
		end
	end

endmodule : aspc_top

// [verif/aspc_properties.sv]
// Checker: port-level properties of the audio serial port controller
`timescale 1ns/10ps
module aspc_properties
	import aspc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Codec pins and DMA
	input wire aspc_pins_out_t pins,
	input wire aspc_dma_t dma
);
	// ********
	// Sequences and properties
	// ********
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// Setup cycle of a transfer, and a completed control write
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_ctl_wr;
		psel && penable && pready && pwrite && paddr == ASPC_OFF_CONTROL;
	endsequence

	property p_zero_wait;
		s_setup |=> psel && penable && pready;
	endproperty
	property p_one_cycle;
		pready |=> !pready;
	endproperty
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	property p_err_bad;
		s_setup ##0 (paddr > ASPC_OFF_RX_FIFO || paddr[1:0] != 2'h0) |=> pslverr;
	endproperty
	property p_ok_mapped;
		s_setup ##0 (paddr <= ASPC_OFF_RX_FIFO && paddr[1:0] == 2'h0) |=> !pslverr;
	endproperty
	property p_oe_pair;
		pins.bclk_oe == pins.lrclk_oe;
	endproperty
	property p_master_oe;
		s_ctl_wr ##0 (pwdata[ASPC_CON_ENABLE] && !pwdata[ASPC_CON_SLAVE]) |-> ##[1:3] pins.bclk_oe;
	endproperty
	property p_slave_oe;
		s_ctl_wr ##0 pwdata[ASPC_CON_SLAVE] |-> ##[1:3] !pins.bclk_oe;
	endproperty
	property p_tx_dma;
		s_ctl_wr ##0 (pwdata[20] && pwdata[18] && pwdata[0]) |-> ##[1:4] dma.tx_req;
	endproperty
	property p_rx_clear;
		s_ctl_wr ##0 pwdata[ASPC_CON_RX_CLR] |-> ##[1:4] !dma.rx_req;
	endproperty

	a_zero_wait: assert property (p_zero_wait) else $error("no zero-wait answer");
	a_one_cycle: assert property (p_one_cycle) else $error("pready longer than a cycle");
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
	a_err_bad: assert property (p_err_bad) else $error("bad offset not refused");
	a_ok_mapped: assert property (p_ok_mapped) else $error("mapped offset refused");
	a_oe_pair: assert property (p_oe_pair) else $error("clock enables differ");
	a_master_oe: assert property (p_master_oe) else $error("master clocks not driven");
	a_slave_oe: assert property (p_slave_oe) else $error("slave clocks driven");
	a_tx_dma: assert property (p_tx_dma) else $error("tx dma request missing");
	a_rx_clear: assert property (p_rx_clear) else $error("rx request after clear");
endmodule : aspc_properties

// [verif/aspc_codec_model.sv]
// Behavioural codec that clocks the link and sends one repeated sample
`timescale 1ns/10ps
module aspc_codec_model
(
	// Clock and control
	input wire logic clock,
	input wire logic run,
	input wire logic [31:0] sample,
	// Link pins
	output logic bclk,
	output logic lrclk,
	output logic data
);
	logic [1:0] div;
	logic [4:0] cnt;

	// ********
	// Link generation
	// ********
	// Start state of the link
	initial
	begin
		bclk = 1'b0;
		lrclk = 1'b0;
		data = 1'b0;
		div = 2'h0;
		cnt = 5'h0;
	end

	// Bit clock only within a stream; idle data keeps changing
	always @(posedge clock)
	begin
		if (!run)
		begin
			bclk <= 1'b0;
			div <= 2'h0;
			data <= ~data;
		end
		else
		begin
			div <= div + 2'h1;
			if (div == 2'h3)
			begin
				bclk <= ~bclk;
				if (bclk)
				begin
					cnt <= cnt + 5'h1;
					if (cnt == 5'h1F)
						lrclk <= ~lrclk;
					data <= sample[~cnt];
				end
			end
		end
	end
endmodule : aspc_codec_model

// [verif/tb_aspc_top.sv]
// Testbench of the audio serial port controller
`timescale 1ns/10ps
module tb_aspc_top
	import aspc_pkg::*;
;
	localparam logic [31:0] SAMPLE = 32'hA5C3_96E1;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, er, run;
	logic bclk_i, lrclk_i, data_i;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	aspc_pins_out_t pins;
	aspc_dma_t dma;
	int n_errors, tests_run, cycles, n;

	// ********
	// Harness
	// ********
	aspc_top u_aspc_top (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bclk_i(bclk_i), .lrclk_i(lrclk_i), .data_i(data_i),
		.pins(pins), .dma(dma), .irq(irq));
	aspc_codec_model u_aspc_codec_model (.clock(clock), .run(run), .sample(SAMPLE),
		.bclk(bclk_i), .lrclk(lrclk_i), .data(data_i));

	// Clock generation
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Cut a hang short
	initial
	begin
		cycles = 0;
		forever
		begin
			@(posedge clock);
			cycles++;
			if (cycles == 20000)
			begin
				n_errors++;
				conclude();
			end
		end
	end

	task conclude;
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; read data and error land in rd and er
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task settle;
		repeat (3) @(posedge clock);
	endtask : settle

	// Cycles of one full period of the bit clock or master clock
	task period(input logic m);
		while ((m ? pins.mclk_o : pins.bclk_o) !== 1'b0) @(posedge clock);
		while ((m ? pins.mclk_o : pins.bclk_o) !== 1'b1) @(posedge clock);
		n = 0;
		do begin @(posedge clock); n++; end while ((m ? pins.mclk_o : pins.bclk_o) !== 1'b0);
		do begin @(posedge clock); n++; end while ((m ? pins.mclk_o : pins.bclk_o) !== 1'b1);
	endtask : period

	// ********
	// Scenarios
	// ********
	task t_reset;
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b0, 8'(4 * i), 32'h0);
			chk(rd, ASPC_RESET_ZERO);
		end
		xfer(1'b0, ASPC_OFF_STATUS, 32'h0);
		chk(rd, ASPC_STATUS_RESET);
		xfer(1'b0, 8'h18, 32'h0);
		chk({rd[30:0], er}, 32'h1);
	endtask : t_reset

	task t_masks;
		xfer(1'b1, ASPC_OFF_CLKDIV, 32'hFFFF_FFFF);
		xfer(1'b0, ASPC_OFF_CLKDIV, 32'h0);
		chk(rd, ASPC_CLKDIV_MASK);
		xfer(1'b1, ASPC_OFF_IRQ_EN, 32'hFFFF_FFFF);
		xfer(1'b0, ASPC_OFF_IRQ_EN, 32'h0);
		chk(rd, ASPC_IE_MASK);
		xfer(1'b1, ASPC_OFF_IRQ_EN, 32'h0);
		xfer(1'b1, ASPC_OFF_CONTROL, 32'h01BC_FFF8);
		xfer(1'b0, ASPC_OFF_CONTROL, 32'h0);
		chk(rd, 32'h01B0_FFF8);
		xfer(1'b1, ASPC_OFF_CONTROL, 32'h0);
	endtask : t_masks

	task t_tx;
		xfer(1'b1, ASPC_OFF_CONTROL, 32'h0014_0001);
		settle();
		chk(32'(dma.tx_req), 32'h1);
		for (int i = 0; i < 8; i++)
			xfer(1'b1, ASPC_OFF_TX_FIFO, 32'h100 + i);
		settle();
		chk(32'(dma.tx_req), 32'h0);
		xfer(1'b0, ASPC_OFF_STATUS, 32'h0);
		chk(rd & 32'hF00F_0000, 32'h8008_0000);
		xfer(1'b1, ASPC_OFF_IRQ_EN, 32'h0000_0200);
		xfer(1'b1, ASPC_OFF_TX_FIFO, 32'h0);
		xfer(1'b0, ASPC_OFF_STATUS, 32'h0);
		chk(rd & 32'hF00F_0007, 32'h800A_0005);
		chk(32'(irq), 32'h1);
		xfer(1'b1, ASPC_OFF_STATUS, 32'h0002_0000);
		settle();
		chk(32'(irq), 32'h0);
		xfer(1'b1, ASPC_OFF_CONTROL, 32'h0000_0E00);
		xfer(1'b0, ASPC_OFF_STATUS, 32'h0);
		chk(rd & 32'h0004_0000, 32'h0);
		xfer(1'b1, ASPC_OFF_CONTROL, 32'h0004_0E00);
		xfer(1'b0, ASPC_OFF_STATUS, 32'h0);
		chk(rd & 32'hF01F_0000, 32'h0014_0000);
		xfer(1'b1, ASPC_OFF_IRQ_EN, 32'h0000_0400);
		settle();
		chk(32'(irq), 32'h1);
		xfer(1'b1, ASPC_OFF_IRQ_EN, 32'h0);
	endtask : t_tx

	task t_rx_udf;
		xfer(1'b1, ASPC_OFF_CONTROL, 32'h0008_0000);
		xfer(1'b0, ASPC_OFF_RX_FIFO, 32'h0);
		xfer(1'b0, ASPC_OFF_STATUS, 32'h0);
		chk(rd & 32'h0000_1100, 32'h0000_1100);
		xfer(1'b1, ASPC_OFF_IRQ_EN, 32'h1);
		settle();
		chk(32'(irq), 32'h1);
		xfer(1'b1, ASPC_OFF_STATUS, 32'h100);
		settle();
		chk(32'(irq), 32'h0);
		xfer(1'b1, ASPC_OFF_IRQ_EN, 32'h0);
	endtask : t_rx_udf

	task t_clocks;
		xfer(1'b1, ASPC_OFF_CLKDIV, 32'h0000_0103);
		xfer(1'b1, ASPC_OFF_CONTROL, 32'h0000_8001);
		period(1'b0);
		chk(32'(n), 32'(2 * (1 + 1)));
		period(1'b1);
		chk(32'(n), 32'(2 * 3));
		chk(32'(pins.bclk_oe), 32'h1);
		xfer(1'b1, ASPC_OFF_CONTROL, 32'h0);
	endtask : t_clocks

	task t_rx_stream;
		run <= 1'b1;
		xfer(1'b1, ASPC_OFF_CONTROL, 32'h0020_0135);
		do xfer(1'b0, ASPC_OFF_STATUS, 32'h0); while (!(rd[27:24] >= 4'h2));
		chk(32'(pins.bclk_oe), 32'h0);
		chk(rd & 32'h0000_0400, 32'h0000_0400);
		chk(32'(dma.rx_req), 32'h1);
		xfer(1'b0, ASPC_OFF_RX_FIFO, 32'h0);
		chk(rd, SAMPLE);
		run <= 1'b0;
		xfer(1'b1, ASPC_OFF_CONTROL, 32'h0008_0000);
	endtask : t_rx_stream

	// Main sequence
	initial
	begin
		n_errors = 0;
		tests_run = 0;
		rst_n = 1'b0;
		run = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_masks();
		t_tx();
		t_rx_udf();
		t_clocks();
		t_rx_stream();
		conclude();
	end
endmodule : tb_aspc_top

bind aspc_top aspc_properties u_aspc_properties (.clock(clock), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .pins(pins), .dma(dma));
